/* File: rtl/tmr2_pkg.sv */
// Purpose: Constants shared by the timer two block
// Assumes: Byte wide register port with byte addresses
// Notes: Offsets other than the control register are local choices
package tmr2_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] CONTROL_ADDR = 8'hc8;
  localparam logic [7:0] MODE_ADDR = 8'hc9;
  localparam logic [7:0] RELOAD_LOW_ADDR = 8'hca;
  localparam logic [7:0] RELOAD_HIGH_ADDR = 8'hcb;
  localparam logic [7:0] COUNT_LOW_ADDR = 8'hcc;
  localparam logic [7:0] COUNT_HIGH_ADDR = 8'hcd;

  // ==========================================================
  // Control register fields
  localparam int OVF_BIT = 7;
  localparam int EXT_BIT = 6;
  localparam int RX_SEL_BIT = 5;
  localparam int TX_SEL_BIT = 4;
  localparam int EXEN_BIT = 3;
  localparam int RUN_BIT = 2;
  localparam int CT_SEL_BIT = 1;
  localparam int CP_RL_BIT = 0;

  // Mode register fields
  localparam int CLK_OUT_EN_BIT = 1;
  localparam int DOWN_EN_BIT = 0;
  localparam logic [7:0] MODE_MASK = 8'h03;

  // ==========================================================
  // Reset values
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // ==========================================================
  // Counter constants
  localparam logic [15:0] COUNT_TOP = 16'hffff;
  localparam logic [15:0] COUNT_BELOW_TOP = 16'hfffe;
  localparam int SYS_DIV = 6;
  localparam logic [2:0] SYS_DIV_LAST = 3'(SYS_DIV - 1);
endpackage

/* File: rtl/tmr2_timer.sv */
// Purpose: Sixteen bit timer/counter with capture, auto-reload,
//   baud overflow feed and programmable clock output
// Assumes: Firmware reaches registers over a plain strobe port
// Notes: Flags set by hardware win over a firmware clear
//
// Contract
// - Count is two cascaded bytes; low byte carry advances high byte.
// - Mode is decoded from baud selects, capture select, clock-out and down-count enables.
// - Counter/timer select picks prescaled clock (undivided in clock-out) or falling count pin edges.
// - Counter advances only while run control is set.
// - Capture mode trigger fall copies count into capture bytes, sets flag.
// - Capture mode counts freely and sets overflow flag on rollover.
// - Down-count enable is cleared at reset.
// - Up-only auto-reload rollover sets overflow flag and loads reload.
// - Up-only with external enable, trigger fall reloads and sets flag.
// - Up/down with trigger high counts up, reloads on FFFF overflow.
// - Up/down with trigger low counts down, loads FFFF at reload match.
// - Up/down toggles external flag each wrap, without an interrupt.
// - Baud selects route own or timer one overflows to serial clocks.
// - Overflow flag cleared only by firmware, never set in baud mode.
// - Baud mode forces auto-reload and ignores trigger events.
// - External enable clear makes trigger falls ignored; up/down still reads pin as direction.
// - Clock-out mode reloads each overflow, drives 50% clock on pin.
// - Clock-out frequency is clock over two times 65535 minus reload.
// - Clock-out mode overflows raise no interrupt.
// - Clock-out enable feeds divider; timer select drives pin.
// - Baud and clock-out may run together sharing one reload value.
module tmr2_timer (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  // Count input and clock output pin
  input wire logic countPinIn,
  output logic countPinOut,
  output logic countPinOe,
  // Trigger and direction pin
  input wire logic triggerPin,
  // Serial baud clocks
  input wire logic timerOneOvf,
  output logic rxBaudClk,
  output logic txBaudClk,
  // Interrupt request level
  output logic timerIrq
);
  // ==========================================================
  // Registers
  logic [7:0] timer_two_control_reg;
  logic [7:0] timer_two_mode_reg;
  logic [7:0] count_low_byte;
  logic [7:0] count_high_byte;
  logic [7:0] reload_capture_low;
  logic [7:0] reload_capture_high;
  logic clockDivider;
  logic [2:0] sysDivCount;

  // Pin synchronisers and edge history
  logic [1:0] countSync;
  logic countLast;
  logic [1:0] trigSync;
  logic trigLast;

  // ==========================================================
  // Field decode
  logic overflow_flag;
  logic external_flag;
  logic receive_baud_select;
  logic transmit_baud_select;
  logic external_enable;
  logic run_control;
  logic counter_timer_select;
  logic capture_reload_select;
  logic clock_out_enable;
  logic down_count_enable;

  assign overflow_flag = timer_two_control_reg[tmr2_pkg::OVF_BIT];
  assign external_flag = timer_two_control_reg[tmr2_pkg::EXT_BIT];
  assign receive_baud_select = timer_two_control_reg[tmr2_pkg::RX_SEL_BIT];
  assign transmit_baud_select = timer_two_control_reg[tmr2_pkg::TX_SEL_BIT];
  assign external_enable = timer_two_control_reg[tmr2_pkg::EXEN_BIT];
  assign run_control = timer_two_control_reg[tmr2_pkg::RUN_BIT];
  assign counter_timer_select = timer_two_control_reg[tmr2_pkg::CT_SEL_BIT];
  assign capture_reload_select = timer_two_control_reg[tmr2_pkg::CP_RL_BIT];
  assign clock_out_enable = timer_two_mode_reg[tmr2_pkg::CLK_OUT_EN_BIT];
  assign down_count_enable = timer_two_mode_reg[tmr2_pkg::DOWN_EN_BIT];

  // ==========================================================
  // Mode decode
  logic baudMode;
  logic captureMode;
  logic clockOutMode;
  logic upDownMode;
  logic reloadMode;

  assign baudMode = receive_baud_select | transmit_baud_select;
  assign captureMode = !baudMode && capture_reload_select;
  assign clockOutMode = clock_out_enable && !capture_reload_select;
  assign reloadMode = !captureMode;
  assign upDownMode = down_count_enable && !baudMode && !captureMode
    && !clockOutMode;

  // ==========================================================
  // Pin synchronisers
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      countSync <= 2'h3;
      countLast <= 1'h1;
      trigSync <= 2'h3;
      trigLast <= 1'h1;
    end else begin
      countSync <= {countSync[0], countPinIn};
      countLast <= countSync[1];
      trigSync <= {trigSync[0], triggerPin};
      trigLast <= trigSync[1];
    end
  end

  logic countFall;
  logic trigFall;
  logic trigLevel;

  assign countFall = countLast && !countSync[1];
  assign trigFall = trigLast && !trigSync[1];
  assign trigLevel = trigSync[1];

  // ==========================================================
  // System clock prescaler
  logic sysTick;

  assign sysTick = (sysDivCount == tmr2_pkg::SYS_DIV_LAST);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sysDivCount <= 3'h0;
    end else if (sysTick) begin
      sysDivCount <= 3'h0;
    end else begin
      sysDivCount <= sysDivCount + 3'h1;
    end
  end

  // ==========================================================
  // Count event and wrap detection
  logic [15:0] countValue;
  logic [15:0] reloadValue;
  logic countTick;
  logic countDown;
  logic overflowHit;
  logic underflowHit;
  logic wrapEvent;
  logic triggerEvent;

  assign countValue = {count_high_byte, count_low_byte};
  assign reloadValue = {reload_capture_high, reload_capture_low};

  // Clock-out runs on the internal clock every cycle
  always_comb begin
    if (counter_timer_select) begin
      countTick = run_control && countFall;
    end else if (clockOutMode) begin
      countTick = run_control;
    end else begin
      countTick = run_control && sysTick;
    end
  end

  assign countDown = upDownMode && !trigLevel;

  // Clock-out wraps one step early to give 65535 minus reload ticks
  always_comb begin
    if (clockOutMode && !counter_timer_select) begin
      overflowHit = countTick && (countValue == tmr2_pkg::COUNT_BELOW_TOP
        || countValue == tmr2_pkg::COUNT_TOP);
    end else begin
      overflowHit = countTick && !countDown
        && (countValue == tmr2_pkg::COUNT_TOP);
    end
  end

  assign underflowHit = countTick && countDown
    && (countValue == reloadValue);
  assign wrapEvent = overflowHit || underflowHit;
  // Up/down mode reads the trigger pin as direction only
  assign triggerEvent = trigFall && external_enable && !baudMode
    && !upDownMode;

  // ==========================================================
  // Register port decode
  logic wrControl;
  logic wrMode;
  logic wrReloadLow;
  logic wrReloadHigh;
  logic wrCountLow;
  logic wrCountHigh;

  function automatic logic addrHit(input logic [7:0] addr,
                                   input logic [7:0] target);
    addrHit = (addr == target);
  endfunction

  assign wrControl = regWrite && addrHit(regAddr, tmr2_pkg::CONTROL_ADDR);
  assign wrMode = regWrite && addrHit(regAddr, tmr2_pkg::MODE_ADDR);
  assign wrReloadLow = regWrite
    && addrHit(regAddr, tmr2_pkg::RELOAD_LOW_ADDR);
  assign wrReloadHigh = regWrite
    && addrHit(regAddr, tmr2_pkg::RELOAD_HIGH_ADDR);
  assign wrCountLow = regWrite && addrHit(regAddr, tmr2_pkg::COUNT_LOW_ADDR);
  assign wrCountHigh = regWrite
    && addrHit(regAddr, tmr2_pkg::COUNT_HIGH_ADDR);

  // ==========================================================
  // Counter bytes
  logic [15:0] next_count;
  logic lowCarry;
  logic lowBorrow;

  assign lowCarry = (count_low_byte == 8'hff);
  assign lowBorrow = (count_low_byte == 8'h00);

  // Capture mode runs free and wraps to zero
  always_comb begin
    next_count = countValue;
    if (wrapEvent) begin
      if (underflowHit) begin
        next_count = tmr2_pkg::COUNT_TOP;
      end else if (captureMode) begin
        next_count = 16'h0000;
      end else begin
        next_count = reloadValue;
      end
    end else if (triggerEvent && reloadMode) begin
      next_count = reloadValue;
    end else if (countTick) begin
      if (countDown) begin
        next_count[7:0] = count_low_byte - 8'h01;
        next_count[15:8] = count_high_byte - {7'h00, lowBorrow};
      end else begin
        next_count[7:0] = count_low_byte + 8'h01;
        next_count[15:8] = count_high_byte + {7'h00, lowCarry};
      end
    end
  end

  // Firmware writes land immediately and override counting
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      count_low_byte <= tmr2_pkg::BYTE_RESET;
      count_high_byte <= tmr2_pkg::BYTE_RESET;
    end else begin
      count_low_byte <= wrCountLow ? regWrData : next_count[7:0];
      count_high_byte <= wrCountHigh ? regWrData : next_count[15:8];
    end
  end

  // ==========================================================
  // Reload and capture bytes
  logic captureEvent;

  assign captureEvent = triggerEvent && captureMode;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      reload_capture_low <= tmr2_pkg::BYTE_RESET;
      reload_capture_high <= tmr2_pkg::BYTE_RESET;
    end else if (captureEvent) begin
      reload_capture_low <= count_low_byte;
      reload_capture_high <= count_high_byte;
    end else begin
      if (wrReloadLow) begin
        reload_capture_low <= regWrData;
      end
      if (wrReloadHigh) begin
        reload_capture_high <= regWrData;
      end
    end
  end

  // ==========================================================
  // Control register with hardware flags
  logic setOverflow;
  logic setExternal;
  logic toggleExternal;
  logic [7:0] baseControl;
  logic [7:0] next_control;

  assign setOverflow = wrapEvent && !baudMode
    && !clockOutMode;
  assign setExternal = triggerEvent;
  assign toggleExternal = wrapEvent && upDownMode;

  // Hardware set wins over a firmware clear in the same cycle
  // A wrap toggle acts on the value just written
  always_comb begin
    baseControl = wrControl ? regWrData : timer_two_control_reg;
    next_control = baseControl;
    if (setOverflow) begin
      next_control[tmr2_pkg::OVF_BIT] = 1'b1;
    end
    if (setExternal) begin
      next_control[tmr2_pkg::EXT_BIT] = 1'b1;
    end else if (toggleExternal) begin
      next_control[tmr2_pkg::EXT_BIT] =
        !baseControl[tmr2_pkg::EXT_BIT];
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      timer_two_control_reg <= tmr2_pkg::CONTROL_RESET;
    end else begin
      timer_two_control_reg <= next_control;
    end
  end

  // ==========================================================
  // Mode register
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      timer_two_mode_reg <= tmr2_pkg::MODE_RESET;
    end else if (wrMode) begin
      timer_two_mode_reg <= regWrData & tmr2_pkg::MODE_MASK;
    end
  end

  // ==========================================================
  // Clock-out divide-by-two stage
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      clockDivider <= 1'b0;
    end else if (clock_out_enable && wrapEvent) begin
      clockDivider <= !clockDivider;
    end
  end

  assign countPinOut = clockDivider;
  assign countPinOe = clock_out_enable && !counter_timer_select;

  // ==========================================================
  // Baud clock routing and interrupt request
  // Baud outputs carry the raw one-cycle wrap pulse
  assign rxBaudClk = receive_baud_select ? wrapEvent : timerOneOvf;
  assign txBaudClk = transmit_baud_select ? wrapEvent : timerOneOvf;
  assign timerIrq = overflow_flag
    || (external_flag && !down_count_enable);

  // ==========================================================
  // Read data, one cycle after the strobe
  // Unmapped addresses read as zero
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      regRdData <= 8'h00;
    end else if (regRead) begin
      unique case (regAddr)
        tmr2_pkg::CONTROL_ADDR: regRdData <= timer_two_control_reg;
        tmr2_pkg::MODE_ADDR: regRdData <= timer_two_mode_reg;
        tmr2_pkg::RELOAD_LOW_ADDR: regRdData <= reload_capture_low;
        tmr2_pkg::RELOAD_HIGH_ADDR: regRdData <= reload_capture_high;
        tmr2_pkg::COUNT_LOW_ADDR: regRdData <= count_low_byte;
        tmr2_pkg::COUNT_HIGH_ADDR: regRdData <= count_high_byte;
        default: regRdData <= 8'h00;
      endcase
    end else begin
      regRdData <= 8'h00;
    end
  end
endmodule

/* File: testbench/tmr2_timer_sva.sv */
// Purpose: Port checks for the timer two block
// Assumes: Shadows of control and mode follow firmware writes
// Notes: Bound into every timer instance
module tmr2_timer_chk (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regRdData,
  // Pins and serial clocks
  input wire logic countPinOut,
  input wire logic countPinOe,
  input wire logic timerOneOvf,
  input wire logic rxBaudClk,
  input wire logic txBaudClk,
  input wire logic timerIrq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] ctl;
  logic [1:0] md;
  logic clkOut;
  // ==========================================================
  // Firmware shadows
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctl <= 8'h00;
    end else if (regWrite && regAddr == tmr2_pkg::CONTROL_ADDR) begin
      ctl <= regWrData;
    end
  end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      md <= 2'h0;
    end else if (regWrite && regAddr == tmr2_pkg::MODE_ADDR) begin
      md <= regWrData[1:0];
    end
  end
  assign clkOut = md[1] & ~ctl[1];
  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  property p_rdIdle;
    !$past(regRead) |-> regRdData == 8'h00;
  endproperty
  a_rdIdle: assert property (p_rdIdle) else $error("stray read data");
  property p_modeRd;
    regRead && regAddr == tmr2_pkg::MODE_ADDR |=> regRdData == {6'h00, md};
  endproperty
  a_modeRd: assert property (p_modeRd) else $error("mode readback");
  property p_unmap;
    regRead && (regAddr < tmr2_pkg::CONTROL_ADDR ||
      regAddr > tmr2_pkg::COUNT_HIGH_ADDR) |=> regRdData == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_rxMux;
    !ctl[5] |-> rxBaudClk == timerOneOvf;
  endproperty
  a_rxMux: assert property (p_rxMux) else $error("rx baud source");
  property p_txMux;
    !ctl[4] |-> txBaudClk == timerOneOvf;
  endproperty
  a_txMux: assert property (p_txMux) else $error("tx baud source");
  property p_oeOff;
    !clkOut |-> !countPinOe;
  endproperty
  a_oeOff: assert property (p_oeOff) else $error("pin driven");
  property p_pinStill;
    !md[1] |=> $stable(countPinOut);
  endproperty
  a_pinStill: assert property (p_pinStill) else $error("pin moved");
  property p_baudQuiet;
    (ctl[5] || ctl[4]) && !timerIrq && !regWrite |=> !timerIrq;
  endproperty
  a_baudQuiet: assert property (p_baudQuiet) else $error("baud irq");
endmodule

bind tmr2_timer tmr2_timer_chk i_tmr2_timer_chk (.clk_sys, .rstn, .regAddr,
  .regWrData, .regWrite, .regRead, .regRdData, .countPinOut, .countPinOe,
  .timerOneOvf, .rxBaudClk, .txBaudClk, .timerIrq);

/* File: testbench/tmr2_pins.sv */
// Purpose: Far-side model of trigger, count pin and timer one
// Assumes: Bench requests one-cycle pulses
// Notes: Released pins rest high as if pulled up
module tmr2_pins (
  // Clock
  input wire logic clk_sys,
  // Bench requests
  input wire logic trigFall,
  input wire logic trigHoldLow,
  input wire logic cntPulse,
  // Pin levels
  output logic triggerPin,
  output logic countPinIn,
  output logic timerOneOvf
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] trigLeft = 3'h0;
  logic [2:0] cntLeft = 3'h0;
  logic [2:0] ovfPhase = 3'h0;
  // Low phases of four cycles, above the two-cycle minimum
  always @(posedge clk_sys) begin
    trigLeft <= trigFall ? 3'h4 : trigLeft - 3'(trigLeft != 3'h0);
    cntLeft <= cntPulse ? 3'h4 : cntLeft - 3'(cntLeft != 3'h0);
    ovfPhase <= ovfPhase + 3'h1;
  end
  assign triggerPin = !(trigHoldLow || trigLeft != 3'h0);
  assign countPinIn = cntLeft == 3'h0;
  assign timerOneOvf = ovfPhase == 3'h7;
endmodule

/* File: testbench/tmr2_timer_tb.sv */
// Purpose: Self-checking bench for the timer two block
// Assumes: Timer ticks every six clocks
// Notes: Pin model drives trigger and count pins
module tmr2_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] CTL = tmr2_pkg::CONTROL_ADDR;
  localparam logic [7:0] MD = tmr2_pkg::MODE_ADDR;
  localparam logic [7:0] RLD = tmr2_pkg::RELOAD_LOW_ADDR;
  localparam logic [7:0] CNT = tmr2_pkg::COUNT_LOW_ADDR;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic trigFall = 1'b0;
  logic trigHoldLow = 1'b0;
  logic cntPulse = 1'b0;
  logic [7:0] regRdData;
  logic countPinOut, countPinOe, pinLevel, countWire, triggerPin;
  logic timerOneOvf, rxBaudClk, txBaudClk, timerIrq;
  int failures = 0;
  int checks_done = 0;
  always #2.5 clk_sys = ~clk_sys;
  assign countWire = countPinOe ? countPinOut : pinLevel;
  tmr2_timer i_tmr2_timer (.clk_sys, .rstn, .regAddr, .regWrData, .regWrite,
    .regRead, .regRdData, .countPinIn(countWire), .countPinOut, .countPinOe,
    .triggerPin, .timerOneOvf, .rxBaudClk, .txBaudClk, .timerIrq);
  tmr2_pins i_tmr2_pins (.clk_sys, .trigFall, .trigHoldLow, .cntPulse,
    .triggerPin, .countPinIn(pinLevel), .timerOneOvf);
  // ==========================================================
  // Shared tasks
  task automatic conclude();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e,
    input logic [15:0] s);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1 d = regRdData;
    @(posedge clk_sys);
  endtask
  task automatic rc(input string nm, input logic [7:0] a,
    input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(nm, {8'h00, e}, {8'h00, d});
  endtask
  task automatic rc16(input string nm, input logic [7:0] a,
    input logic [15:0] e);
    logic [15:0] d;
    rd(a, d[7:0]);
    rd(a + 8'h01, d[15:8]);
    chk(nm, e, d);
  endtask
  task automatic wr16(input logic [7:0] a, input logic [15:0] d);
    wr(a, d[7:0]);
    wr(a + 8'h01, d[15:8]);
  endtask
  task automatic waitIrq();
    int i;
    for (i = 0; i < 80 && timerIrq !== 1'b1; i++) @(posedge clk_sys);
    if (i == 80) begin
      chk("irqWait", 16'h0001, 16'h0000);
      conclude();
    end
  endtask
  task automatic waitPin(input logic lvl);
    int i;
    for (i = 0; i < 20 && countPinOut !== lvl; i++) @(negedge clk_sys);
    if (i == 20) begin
      chk("pinWait", 16'h0001, 16'h0000);
      conclude();
    end
  endtask
  task automatic trig();
    trigFall <= 1'b1;
    @(posedge clk_sys);
    trigFall <= 1'b0;
    repeat (9) @(posedge clk_sys);
  endtask
  // ==========================================================
  // Scenarios
  task automatic sRegs();
    rc("ctlReset", CTL, 8'h00);
    rc("modeReset", MD, 8'h00);
    wr(8'h10, 8'hff);
    rc("unmapped", 8'h10, 8'h00);
    wr16(CNT, 16'h12ff);
    rc16("countRw", CNT, 16'h12ff);
  endtask
  task automatic sReload();
    wr16(RLD, 16'hfffc);
    wr16(CNT, 16'hfffe);
    wr(CTL, 8'h04);
    waitIrq();
    wr(CTL, 8'h80);
    rc16("reloaded", CNT, 16'hfffc);
    rc("ovfFlag", CTL, 8'h80);
    repeat (20) @(posedge clk_sys);
    rc16("held", CNT, 16'hfffc);
  endtask
  task automatic sCounter();
    wr16(CNT, 16'h00fe);
    wr(CTL, 8'h06);
    repeat (3) begin
      cntPulse <= 1'b1;
      @(posedge clk_sys);
      cntPulse <= 1'b0;
      repeat (9) @(posedge clk_sys);
    end
    rc16("pinCount", CNT, 16'h0101);
    wr(CTL, 8'h00);
  endtask
  task automatic sCapture();
    wr16(CNT, 16'h1234);
    wr(CTL, 8'h01);
    trig();
    rc("exenOff", CTL, 8'h01);
    rc16("noCapture", RLD, 16'hfffc);
    wr(CTL, 8'h09);
    trig();
    rc16("captured", RLD, 16'h1234);
    rc("extFlag", CTL, 8'h49);
    chk("irqCap", 16'h0001, {15'h0, timerIrq});
    wr16(CNT, 16'h0000);
    wr(CTL, 8'h08);
    trig();
    rc16("trigReload", CNT, 16'h1234);
  endtask
  task automatic sUpDown();
    trigHoldLow <= 1'b1;
    wr(MD, 8'h01);
    wr16(RLD, 16'h0000);
    wr16(CNT, 16'h0002);
    wr(CTL, 8'h04);
    waitIrq();
    rc("underflow", CTL, 8'hc4);
    wr(CTL, 8'h40);
    chk("irqExt", 16'h0000, {15'h0, timerIrq});
    trigHoldLow <= 1'b0;
    wr16(RLD, 16'h1111);
    wr16(CNT, 16'hfffe);
    wr(CTL, 8'h44);
    waitIrq();
    rc("upWrap", CTL, 8'h84);
    wr(CTL, 8'h00);
    rc16("upReload", CNT, 16'h1111);
    wr(MD, 8'h00);
  endtask
  task automatic sBaud();
    int n;
    int m;
    n = 0;
    m = 0;
    wr16(RLD, 16'hffff);
    wr16(CNT, 16'hffff);
    wr(CTL, 8'h3c);
    trig();
    repeat (60) begin
      @(negedge clk_sys);
      n += int'(rxBaudClk === 1'b1);
      m += int'(txBaudClk === 1'b1);
    end
    @(posedge clk_sys);
    chk("baudTicks", 16'h0001, {15'h0, n >= 9 && n <= 11});
    chk("txBaudTicks", 16'h0001, {15'h0, m >= 9 && m <= 11});
    rc("noFlags", CTL, 8'h3c);
    wr(CTL, 8'h00);
  endtask
  task automatic sClkOut();
    int n;
    int i;
    n = 0;
    wr16(RLD, 16'hfffb);
    wr16(CNT, 16'hfffb);
    wr(MD, 8'h02);
    wr(CTL, 8'h04);
    chk("pinDrive", 16'h0001, {15'h0, countPinOe});
    waitPin(1'b0);
    waitPin(1'b1);
    for (i = 0; i < 20 && countPinOut === 1'b1; i++) begin
      @(negedge clk_sys);
      n++;
    end
    @(posedge clk_sys);
    chk("halfPeriod", 16'h0004, 16'(n));
    chk("irqOut", 16'h0000, {15'h0, timerIrq});
    rc("noFlag", CTL, 8'h04);
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    sRegs();
    sReload();
    sCounter();
    sCapture();
    sUpDown();
    sBaud();
    sClkOut();
    conclude();
  end
endmodule
